/* src/tmode_pkg.sv */
// constants for the board test mode decode and xor tree
`default_nettype none
package tmode_pkg;
  localparam int          TREE_PINS_DFLT  = 64;
  localparam int          DIG_PINS_DFLT   = 96;
  localparam int          CLK_SRCS_DFLT   = 4;
  localparam int          SEL_W           = 4;
  localparam logic [3:0]  SEL_XOR_TREE    = 4'h0;
  localparam logic [3:0]  SEL_TRISTATE    = 4'h5;
  localparam logic [7:0]  JTAG_IR_HIGHZ   = 8'h08;
  localparam int          JTAG_IR_W       = 8;
  localparam logic [7:0]  TAP_RESET       = 8'h01;
  localparam logic [7:0]  TAP_IDLE        = 8'h02;
  localparam logic [7:0]  TAP_SEL_DR      = 8'h04;
  localparam logic [7:0]  TAP_SEL_IR      = 8'h08;
  localparam logic [7:0]  TAP_CAP_IR      = 8'h10;
  localparam logic [7:0]  TAP_SHIFT_IR    = 8'h20;
  localparam logic [7:0]  TAP_UPD_IR      = 8'h40;
  localparam logic [7:0]  TAP_DR_OTHER    = 8'h80;
endpackage
`default_nettype wire

/* src/xor_chain.sv */
// cascaded xor chain over the tested pins
`timescale 1ns/10ps
`default_nettype none
module xor_chain #(
  parameter int N = 64
) (
  input  wire logic [N-1:0] pins_in,   // tested pin levels
  output logic              result_out // final stage
);
  if (N < 1)
  begin : g_bad_n
    $error("xor_chain: N must be at least 1");
  end
  logic [N:0] stage;
  assign stage[0] = 1'b0;
  genvar i;
  generate
    for (i = 0; i < N; i++)
    begin : g_st
      assign stage[i+1] = stage[i] ^ pins_in[i];
    end
  endgenerate
  assign result_out = stage[N];
endmodule
`default_nettype wire

/* src/board_test_mode.sv */
// strap decoded xor tree and tristate test modes with tap highz
// Operation
// - all select low enters xor tree
// - select 0101 enters tristate mode
// - tree pins' output drivers go high impedance
// - flash enable pin driven with tree result
// - tree pins act as inputs
// - chained xor stages, one pin each
// - scan, strap, analog, clock pins excluded
// - tristate disables digital outputs except tdo
// - analog and regulator outputs unaffected
// - tap highz instruction tristates digital outputs except tdo, outside xor tree mode
// - tap held reset while trst low
// - clock view output selected by register
// - factory test input low active
`timescale 1ns/10ps
`default_nettype none
module board_test_mode
  import tmode_pkg::*;
#(
  parameter int TREE_PINS = TREE_PINS_DFLT,
  parameter int DIG_PINS  = DIG_PINS_DFLT,
  parameter int CLK_SRCS  = CLK_SRCS_DFLT
) (
  input  wire logic                  mclk_in,                   // core clock 50 MHz
  input  wire logic                  nrst_in,                   // async reset, low
  input  wire logic                  mode_decode_qualifier_low_in, // strap qualifier
  input  wire logic                  select_code_bit3_pin_in,   // select bit 3
  input  wire logic                  select_code_bit2_pin_in,   // select bit 2
  input  wire logic                  select_code_bit1_pin_in,   // select bit 1
  input  wire logic                  select_code_bit0_pin_in,   // select bit 0
  input  wire logic                  factory_test_low_in,       // factory test, low
  input  wire logic [TREE_PINS-1:0]  tree_pins_in,              // tested pin levels
  input  wire logic [DIG_PINS-1:0]   func_oe_in,                // normal output enables
  input  wire logic                  func_flash_ce_low_in,      // normal flash enable
  input  wire logic                  func_flash_ce_oe_in,       // normal flash enable oe
  input  wire logic [CLK_SRCS-1:0]   clk_srcs_in,               // observable clocks
  input  wire logic [$clog2(CLK_SRCS)-1:0] clk_view_sel_in,     // clock select register
  input  wire logic                  jtag_tck_in,               // tap clock, sampled
  input  wire logic                  jtag_tms_in,               // tap mode select
  input  wire logic                  jtag_tdi_in,               // tap data in
  input  wire logic                  jtag_trst_low_in,          // tap reset, low
  output logic                       jtag_tdo_out,              // tap data out
  output logic                       jtag_tdo_oe_out,           // tdo always driven
  output logic [DIG_PINS-1:0]        pin_oe_out,                // final output enables
  output logic                       flash_chip_enable_low_out, // flash enable or tree
  output logic                       flash_chip_enable_oe_out,  // flash enable oe
  output logic                       clk_view_out,              // observed clock
  output logic                       xor_mode_out,              // xor tree mode active
  output logic                       tristate_mode_out,         // global output disable
  output logic                       factory_test_out           // factory test asserted
);
  if (TREE_PINS < 1 || DIG_PINS < 1 || CLK_SRCS < 2)
  begin : g_bad_params
    $error("board_test_mode: bad parameters");
  end

  logic       rst_s1_r;
  logic       rst_s2_r;
  logic       rst_n;
  always_ff @(posedge mclk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      rst_s1_r <= 1'b0;
      rst_s2_r <= 1'b0;
    end
    else
    begin
      rst_s1_r <= 1'b1;
      rst_s2_r <= rst_s1_r;
    end
  end
  assign rst_n = rst_s2_r;

  // strap decode is static; code is bit3..bit0
  logic [SEL_W-1:0] sel_code;
  logic             xor_mode;
  logic             strap_tri;
  assign sel_code  = {select_code_bit3_pin_in, select_code_bit2_pin_in,
                      select_code_bit1_pin_in, select_code_bit0_pin_in};
  assign xor_mode  = !mode_decode_qualifier_low_in && (sel_code == SEL_XOR_TREE);
  assign strap_tri = !mode_decode_qualifier_low_in && (sel_code == SEL_TRISTATE);

  // tap controller; tck sampled on the core clock
  typedef enum logic [7:0] {
    ST_RESET = TAP_RESET, ST_IDLE = TAP_IDLE, ST_SEL_DR = TAP_SEL_DR,
    ST_SEL_IR = TAP_SEL_IR, ST_CAP_IR = TAP_CAP_IR, ST_SHIFT_IR = TAP_SHIFT_IR,
    ST_UPD_IR = TAP_UPD_IR, ST_DR_OTHER = TAP_DR_OTHER
  } tap_e;
  tap_e                 tap_r;
  tap_e                 tap_nxt;
  logic                 tck_d_r;
  logic                 tck_rise;
  logic                 tck_fall;
  logic [JTAG_IR_W-1:0] ir_sh_r;
  logic [JTAG_IR_W-1:0] ir_r;
  logic                 highz;
  logic                 tdo_r;
  logic                 tap_rst;

  assign tap_rst  = !rst_n || !jtag_trst_low_in;
  assign tck_rise = jtag_tck_in && !tck_d_r;
  assign tck_fall = !jtag_tck_in && tck_d_r;

  always_ff @(posedge mclk_in or negedge nrst_in)
  begin
    if (!nrst_in)
      tck_d_r <= 1'b0;
    else
      tck_d_r <= jtag_tck_in;
  end

  // dr path collapsed: dr states only pass through to idle or select ir
  always_comb
  begin
    tap_nxt = tap_r;
    case (tap_r)
      ST_RESET:    tap_nxt = jtag_tms_in ? ST_RESET : ST_IDLE;
      ST_IDLE:     tap_nxt = jtag_tms_in ? ST_SEL_DR : ST_IDLE;
      ST_SEL_DR:   tap_nxt = jtag_tms_in ? ST_SEL_IR : ST_DR_OTHER;
      ST_DR_OTHER: tap_nxt = jtag_tms_in ? ST_IDLE : ST_DR_OTHER;
      ST_SEL_IR:   tap_nxt = jtag_tms_in ? ST_RESET : ST_CAP_IR;
      ST_CAP_IR:   tap_nxt = jtag_tms_in ? ST_UPD_IR : ST_SHIFT_IR;
      ST_SHIFT_IR: tap_nxt = jtag_tms_in ? ST_UPD_IR : ST_SHIFT_IR;
      ST_UPD_IR:   tap_nxt = jtag_tms_in ? ST_SEL_DR : ST_IDLE;
      default:     tap_nxt = ST_RESET;
    endcase
  end

  always_ff @(posedge mclk_in or negedge nrst_in)
  begin
    if (!nrst_in)
      tap_r <= ST_RESET;
    else if (tap_rst)
      tap_r <= ST_RESET;
    else if (tck_rise)
      tap_r <= tap_nxt;
  end

  always_ff @(posedge mclk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      ir_sh_r <= '0;
      ir_r    <= '0;
    end
    else if (tap_rst || tap_r == ST_RESET)
    begin
      ir_sh_r <= '0;
      ir_r    <= '0;
    end
    else if (tck_rise && tap_r == ST_CAP_IR)
      ir_sh_r <= {{(JTAG_IR_W-1){1'b0}}, 1'b1};
    else if (tck_rise && tap_r == ST_SHIFT_IR)
      ir_sh_r <= {jtag_tdi_in, ir_sh_r[JTAG_IR_W-1:1]};
    else if (tck_fall && tap_r == ST_UPD_IR)
      ir_r <= ir_sh_r;
  end

  always_ff @(posedge mclk_in or negedge nrst_in)
  begin
    if (!nrst_in)
      tdo_r <= 1'b0;
    else if (tck_fall)
      tdo_r <= (tap_r == ST_SHIFT_IR) ? ir_sh_r[0] : 1'b0;
  end

  assign highz = (ir_r == JTAG_IR_HIGHZ);

  logic tree_res;
  xor_chain #(.N(TREE_PINS)) u_chain (
    .pins_in    (tree_pins_in), // only tree-tested pins are wired here
    .result_out (tree_res)
  );

  // output enable muxing is combinational so straps act without a clock
  logic glob_tri;
  assign glob_tri = (strap_tri || highz) && !xor_mode;
  always_comb
  begin
    if (xor_mode)
      pin_oe_out = '0;
    else if (glob_tri)
      pin_oe_out = '0;
    else
      pin_oe_out = func_oe_in;
  end

  assign flash_chip_enable_oe_out  = xor_mode ? 1'b1 : (glob_tri ? 1'b0 : func_flash_ce_oe_in);
  assign flash_chip_enable_low_out = xor_mode ? tree_res : func_flash_ce_low_in;
  assign jtag_tdo_out      = tdo_r;
  assign jtag_tdo_oe_out   = 1'b1;       // tdo keeps driving
  assign clk_view_out      = clk_srcs_in[clk_view_sel_in];
  assign xor_mode_out      = xor_mode;
  assign tristate_mode_out = glob_tri;
  assign factory_test_out  = !factory_test_low_in;

  AST_XOR_OE: assert property (@(posedge mclk_in) disable iff (!rst_n)
    xor_mode |-> (pin_oe_out == '0 && flash_chip_enable_oe_out))
    else $error("xor mode left an output enabled");
  AST_XOR_OUT: assert property (@(posedge mclk_in) disable iff (!rst_n)
    xor_mode |-> flash_chip_enable_low_out == ^tree_pins_in)
    else $error("tree result wrong");
  AST_TRI: assert property (@(posedge mclk_in) disable iff (!rst_n)
    (strap_tri && !xor_mode) |-> (pin_oe_out == '0 && jtag_tdo_oe_out && !flash_chip_enable_oe_out))
    else $error("tristate mode left an output enabled");
  AST_NORMAL: assert property (@(posedge mclk_in) disable iff (!rst_n)
    (mode_decode_qualifier_low_in && !highz) |-> pin_oe_out == func_oe_in)
    else $error("normal mode enables changed");
  AST_HIGHZ: assert property (@(posedge mclk_in) disable iff (!rst_n)
    (ir_r == JTAG_IR_HIGHZ && !xor_mode) |-> pin_oe_out == '0)
    else $error("highz left an output enabled");
  AST_TRST: assert property (@(posedge mclk_in) disable iff (!rst_n)
    !jtag_trst_low_in |=> (tap_r == ST_RESET && ir_r == '0))
    else $error("tap not held in reset");
  AST_SEL_DECODE: assert property (@(posedge mclk_in) disable iff (!rst_n)
    (!mode_decode_qualifier_low_in && sel_code == SEL_XOR_TREE) |-> (xor_mode_out && !tristate_mode_out))
    else $error("xor decode wrong");
  AST_TRI_DECODE: assert property (@(posedge mclk_in) disable iff (!rst_n)
    (tristate_mode_out && !highz) |-> (sel_code == SEL_TRISTATE && !mode_decode_qualifier_low_in))
    else $error("tristate decode wrong");
  AST_FTEST: assert property (@(posedge mclk_in) disable iff (!rst_n)
    factory_test_low_in |-> !factory_test_out)
    else $error("factory test active while high");

  COV_XOR:   cover property (@(posedge mclk_in) disable iff (!rst_n) xor_mode ##1 $changed(flash_chip_enable_low_out));
  COV_TRI:   cover property (@(posedge mclk_in) disable iff (!rst_n) strap_tri);
  COV_HIGHZ: cover property (@(posedge mclk_in) disable iff (!rst_n) $rose(highz));
endmodule
`default_nettype wire

/* testbench/fixture_model.sv */
// board fixture and scan tester model driving tree pins and the tap
`timescale 1ns/10ps
`default_nettype none
module fixture_model #(
  parameter int N = 8
) (
  input  wire logic    mclk_in,     // core clock
  output logic [N-1:0] pins_out,    // levels on tested pins
  output logic         tck_out,     // tap clock, still between scans
  output logic         tms_out,     // tap mode select
  output logic         tdi_out,     // tap data in, pulled up when idle
  output logic         trst_low_out // tap reset, pulled down
);
  initial
  begin
    pins_out = '0;
    tck_out = 1'b0;
    tms_out = 1'b1;
    tdi_out = 1'b1;
    trst_low_out = 1'b0;
  end
  task automatic one_pin(input int i, input logic lv);
    @(posedge mclk_in);
    pins_out <= lv ? (N'(1) << i) : '0;
  endtask
  task automatic all_pins(input logic [N-1:0] v);
    @(posedge mclk_in);
    pins_out <= v;
  endtask
  task automatic tap_reset();
    @(posedge mclk_in);
    trst_low_out <= 1'b0;
  endtask
  // tck kept below a quarter of mclk so the sampler sees each edge
  task automatic tap_step(input logic m, input logic d);
    @(posedge mclk_in);
    tms_out <= m;
    tdi_out <= d;
    repeat (4) @(posedge mclk_in);
    tck_out <= 1'b1;
    repeat (4) @(posedge mclk_in);
    tck_out <= 1'b0;
  endtask
  task automatic load_ir(input logic [7:0] v);
    logic [4:0] w = 5'b00110;
    tap_reset();
    repeat (4) @(posedge mclk_in);
    trst_low_out <= 1'b1;
    for (int k = 0; k < 5; k++)
      tap_step(w[k], 1'b1);
    for (int i = 0; i < 8; i++)
      tap_step(i == 7, v[i]);
    tap_step(1'b1, 1'b1);
    tap_step(1'b0, 1'b1);
  endtask
endmodule
`default_nettype wire

/* testbench/xor_tree_tristate_test_mode_tb.sv */
// self-checking bench for strap test modes, xor tree and tap highz
`timescale 1ns/10ps
`default_nettype none
module xor_tree_tristate_test_mode_tb;
  import tmode_pkg::*;
  localparam int NT = 8;
  logic       mclk, nrst, qual, fact_low, fce_low, fce_oe, tck, tms, tdi, trst_low;
  logic       tdo, tdo_oe, fce_out, fce_oe_out, cview, xm, tm, ft;
  logic [3:0] code, srcs;
  logic [1:0] sel;
  logic [7:0] foe, poe, pins;
  int         fails, n_checks;
  board_test_mode #(.TREE_PINS(NT), .DIG_PINS(8), .CLK_SRCS(4)) i_board_test_mode (
    .mclk_in(mclk), .nrst_in(nrst), .mode_decode_qualifier_low_in(qual),
    .select_code_bit3_pin_in(code[3]), .select_code_bit2_pin_in(code[2]),
    .select_code_bit1_pin_in(code[1]), .select_code_bit0_pin_in(code[0]),
    .factory_test_low_in(fact_low), .tree_pins_in(pins), .func_oe_in(foe),
    .func_flash_ce_low_in(fce_low), .func_flash_ce_oe_in(fce_oe), .clk_srcs_in(srcs),
    .clk_view_sel_in(sel), .jtag_tck_in(tck), .jtag_tms_in(tms), .jtag_tdi_in(tdi),
    .jtag_trst_low_in(trst_low), .jtag_tdo_out(tdo), .jtag_tdo_oe_out(tdo_oe), .pin_oe_out(poe),
    .flash_chip_enable_low_out(fce_out), .flash_chip_enable_oe_out(fce_oe_out),
    .clk_view_out(cview), .xor_mode_out(xm), .tristate_mode_out(tm), .factory_test_out(ft));
  fixture_model #(.N(NT)) i_fixture_model (.mclk_in(mclk), .pins_out(pins), .tck_out(tck),
    .tms_out(tms), .tdi_out(tdi), .trst_low_out(trst_low));
  initial
  begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string msg);
    n_checks++;
    if (seen !== exp)
    begin
      fails++;
      $display("[ERR] %0t %s", $time, msg);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d fails %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic straps(input logic q, input logic [3:0] c);
    @(posedge mclk);
    qual <= q;
    code <= c;
    @(negedge mclk);
  endtask
  task automatic t_decode();
    for (int c = 0; c < 16; c++)
    begin
      straps(1'b0, 4'(c));
      chk(8'(xm), 8'(4'(c) == SEL_XOR_TREE), "xor decode");
      chk(8'(tm), 8'(4'(c) == SEL_TRISTATE), "tristate decode");
      chk(8'(tdo_oe), 8'h01, "tdo driven");
      if (4'(c) == SEL_TRISTATE)
        chk({fce_oe_out, poe[6:0]}, 8'h00, "outputs off");
      else if (4'(c) != SEL_XOR_TREE)
        chk(poe, foe, "normal enables");
    end
    for (int k = 0; k < 2; k++)
    begin
      straps(1'b1, k ? SEL_TRISTATE : SEL_XOR_TREE);
      chk({xm, tm, poe[7:2]}, {2'h0, foe[7:2]}, "qualifier high");
      chk(8'({fce_oe_out, fce_out}), 8'({fce_oe, fce_low}), "flash normal");
    end
  endtask
  task automatic t_xor();
    @(posedge mclk);
    fce_oe <= 1'b0;
    straps(1'b0, SEL_XOR_TREE);
    // one pin high at a time gives 1, all low gives the zero seed
    for (int i = 0; i < NT; i++)
      for (int lv = 0; lv < 2; lv++)
      begin
        i_fixture_model.one_pin(i, lv[0]);
        @(negedge mclk);
        chk(8'({fce_oe_out, fce_out}), {6'h00, 1'b1, lv[0]}, "tree output");
        chk(poe, 8'h00, "tree pins released");
      end
    i_fixture_model.all_pins(8'hA7);
    @(negedge mclk);
    chk(8'(fce_out), 8'(^8'hA7), "tree parity");
    straps(1'b1, 4'hF);
    @(posedge mclk);
    fce_oe <= 1'b1;
  endtask
  task automatic t_highz();
    i_fixture_model.load_ir(8'hFF);
    @(negedge mclk);
    chk({tm, poe[6:0]}, {1'b0, foe[6:0]}, "other opcode");
    // walk back to shift ir; the captured 0x01 shows its low bit on tdo at the next tck fall
    for (int k = 0; k < 5; k++)
      i_fixture_model.tap_step(k < 3, 1'b1);
    repeat (2) @(negedge mclk);
    chk(8'(tdo), 8'h01, "capture on tdo");
    i_fixture_model.load_ir(JTAG_IR_HIGHZ);
    repeat (2) @(negedge mclk);
    chk({tm, poe[6:0]}, 8'h80, "highz outputs");
    chk(8'(tdo_oe), 8'h01, "tdo kept");
    i_fixture_model.tap_reset();
    repeat (3) @(negedge mclk);
    chk({tm, poe[6:0]}, {1'b0, foe[6:0]}, "tap reset");
  endtask
  task automatic t_misc();
    // clock view is exercised under tristate mode, which must not touch it
    straps(1'b0, SEL_TRISTATE);
    chk(8'(tm), 8'h01, "tristate for clock view");
    for (int s = 0; s < 4; s++)
    begin
      @(posedge mclk);
      sel <= 2'(s);
      srcs <= 4'h1 << s;
      @(negedge mclk);
      chk(8'(cview), 8'h01, "clock view high");
      @(posedge mclk);
      srcs <= ~(4'h1 << s);
      @(negedge mclk);
      chk(8'(cview), 8'h00, "clock view low");
    end
    for (int v = 0; v < 2; v++)
    begin
      @(posedge mclk);
      fact_low <= v[0];
      @(negedge mclk);
      chk(8'(ft), 8'(!v[0]), "factory test");
    end
  endtask
  initial
  begin
    nrst = 1'b0;
    qual = 1'b1;
    code = 4'hF;
    fact_low = 1'b1;
    fce_low = 1'b0;
    fce_oe = 1'b1;
    srcs = 4'h0;
    sel = 2'h0;
    foe = 8'h3C;
    fails = 0;
    n_checks = 0;
    repeat (4) @(posedge mclk);
    nrst <= 1'b1;
    repeat (3) @(posedge mclk);
    t_decode();
    t_xor();
    t_highz();
    t_misc();
    give_verdict();
  end
  initial
  begin
    repeat (20000) @(posedge mclk);
    fails++;
    give_verdict();
  end
endmodule
`default_nettype wire
